// >>> dsf_top.sv
// Driver status word with protection logic and APB register slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
// Behaviour
// - Standstill bit 31 after 2^20 idle clocks
// - Bit 30 shows quiet chopper active
// - Bits 20:16 return applied current scale
// - Bits 11:8 mirror four temperature comparators
// - Open load bits 7:6, no protective action
// - Low-side short sets bit 5/4, disables driver
// - Ground short sets bit 3/2, disables driver
// - Short flags held until driver switched off
// - Separate short flag set per chopper mode
// - Overtemp limit sets bit 1, bridges off
// - Bridges stay off until prewarning clears
// - One shutdown flag for both bridges
// - Bit 0 shows prewarning threshold exceeded
// - Quiet mode drives coil by voltage PWM
module dsf_top #(
  parameter int STANDSTILL_CYCLES = `DSF_STANDSTILL_CYCLES,
  parameter int PWM_DIV           = `DSF_PWM_DIV
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  step_pulse,
  input  wire logic                  enable_low_input,
  input  wire logic [4:0]            cs_actual,
  input  wire logic [3:0]            temp_cmp,
  input  wire logic                  open_load_phase_a,
  input  wire logic                  open_load_phase_b,
  input  wire logic                  lowside_short_phase_a,
  input  wire logic                  lowside_short_phase_b,
  input  wire logic                  ground_short_phase_a,
  input  wire logic                  ground_short_phase_b,
  output var  logic                  bridge_enable,
  output var  logic                  coil_pwm,
  output var  logic                  irq
);
  import dsf_pkg::*;

  logic [3:0]       chopper_off_time;
  logic             quiet_mode;
  logic             ot_select;
  logic [7:0]       pwm_offset;
  dsf_irq_type      irq_mask;
  dsf_irq_type      irq_status;
  dsf_irq_type      irq_read;
  dsf_irq_type      irq_event;
  dsf_ot_state_type ot_state;
  dsf_ot_state_type next_ot_state;
  dsf_short_type    short_det;
  dsf_short_type    short_set [2];
  dsf_short_type    short_shown;
  dsf_short_type    short_prev;
  logic             stst;
  logic             stst_prev;
  logic             otpw_prev;
  logic [1:0]       ol_prev;
  logic             driver_off;
  logic             shut_cmp;
  logic             warn_cmp;
  logic             next_bridge;
  logic [31:0]      driver_fault_status;
  logic [31:0]      ctrl_word;
  logic [31:0]      next_prdata;
  logic             next_slverr;
  logic             apb_setup;
  logic             apb_done;
  logic             wr_ctrl;
  logic             wr_mask;
  logic             rd_irq;
  logic [7:0]       pwm_cnt;
  logic [7:0]       pwm_duty;
  logic [13:0]      amp_prod;
  logic [8:0]       amp;
  logic             pwm_tick;
  logic [$clog2(PWM_DIV+1)-1:0] div_cnt;

  assign apb_setup = psel & ~penable;
  assign apb_done  = psel & penable & pready;
  assign wr_ctrl   = apb_done & pwrite & (paddr == `DSF_ADDR_CTRL);
  assign wr_mask   = apb_done & pwrite & (paddr == `DSF_ADDR_IRQ_MASK);
  assign rd_irq    = apb_done & ~pwrite & (paddr == `DSF_ADDR_IRQ_STATUS);

  assign short_det = {lowside_short_phase_b, lowside_short_phase_a,
                      ground_short_phase_b, ground_short_phase_a};
  assign driver_off = enable_low_input | (chopper_off_time == 4'h0);
  assign shut_cmp = ot_select ? temp_cmp[`DSF_TEMP_157]
                              : temp_cmp[`DSF_TEMP_150];
  assign warn_cmp = ot_select ? temp_cmp[`DSF_TEMP_143]
                              : temp_cmp[`DSF_TEMP_120];

  // Standstill timer
  dsf_standstill #(
    .CYCLES     (STANDSTILL_CYCLES)
  ) dsf_standstill_inst (
    .pclk       (pclk),
    .presetn    (presetn),
    .step_pulse (step_pulse),
    .stst       (stst)
  );

  // One short flag set per chopper mode, index 1 is the quiet mode
  for (genvar g = 0; g < 2; g++) begin : g_short
    dsf_short_latch dsf_short_latch_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .arm     (quiet_mode == g[0] && !driver_off),
      .clr     (driver_off),
      .det     (short_det),
      .flags   (short_set[g])
    );
  end
  assign short_shown = short_set[quiet_mode];

  // Overtemperature shutdown, common to both bridges
  always_comb begin
    next_ot_state = ot_state;
    case (ot_state)
      DSF_OT_RUN:  if (shut_cmp) next_ot_state = DSF_OT_SHUT;
      DSF_OT_SHUT: if (!shut_cmp && !warn_cmp) begin
        next_ot_state = DSF_OT_RUN;
      end
      default:     next_ot_state = DSF_OT_SHUT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ot_state <= DSF_OT_RUN;
    else          ot_state <= next_ot_state;
  end

  // Bridge enable: open load plays no part here
  assign next_bridge = !driver_off && (short_det == 4'h0) &&
                       (short_shown == 4'h0) && !shut_cmp &&
                       (ot_state == DSF_OT_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bridge_enable <= 1'b0;
    else          bridge_enable <= next_bridge;
  end

  // Status word assembly
  always_comb begin
    driver_fault_status = 32'h0000_0000;
    driver_fault_status[`DSF_BIT_STST] = stst;
    driver_fault_status[`DSF_BIT_QUIET] = quiet_mode;
    driver_fault_status[`DSF_CS_HI:`DSF_CS_LO] = cs_actual;
    driver_fault_status[`DSF_TEMP_HI:`DSF_TEMP_LO] = temp_cmp;
    driver_fault_status[`DSF_OL_HI:`DSF_OL_LO] =
      {open_load_phase_b, open_load_phase_a};
    driver_fault_status[`DSF_SHORT_HI:`DSF_SHORT_LO] = short_shown;
    driver_fault_status[`DSF_BIT_OT] = (ot_state == DSF_OT_SHUT);
    driver_fault_status[`DSF_BIT_OTPW] = warn_cmp;
  end

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`DSF_CTRL_CHOPPER_OFF_TIME_HI:`DSF_CTRL_CHOPPER_OFF_TIME_LO] = chopper_off_time;
    ctrl_word[`DSF_CTRL_QUIET] = quiet_mode;
    ctrl_word[`DSF_CTRL_OTSEL] = ot_select;
    ctrl_word[`DSF_CTRL_OFS_HI:`DSF_CTRL_OFS_LO] = pwm_offset;
  end

  // Read mux, unmapped addresses answer with an error
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `DSF_ADDR_CTRL:       next_prdata = ctrl_word;
      `DSF_ADDR_IRQ_STATUS: next_prdata = {27'h0, irq_status};
      `DSF_ADDR_IRQ_MASK:   next_prdata = {27'h0, irq_mask};
      `DSF_ADDR_STATUS:     next_prdata = pwrite ? 32'h0 : driver_fault_status;
      default:              next_slverr = 1'b1;
    endcase
  end

  // APB answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & next_slverr;
      if (apb_setup) prdata <= next_prdata;
    end
  end

  // Control register; status word has no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chopper_off_time <= `DSF_RST_CHOPPER_OFF_TIME;
      quiet_mode       <= `DSF_RST_QUIET;
      ot_select        <= `DSF_RST_OTSEL;
      pwm_offset       <= `DSF_RST_OFS;
    end else if (wr_ctrl) begin
      if (pstrb[0]) begin
        chopper_off_time <= pwdata[`DSF_CTRL_CHOPPER_OFF_TIME_HI:`DSF_CTRL_CHOPPER_OFF_TIME_LO];
        quiet_mode       <= pwdata[`DSF_CTRL_QUIET];
        ot_select        <= pwdata[`DSF_CTRL_OTSEL];
      end
      if (pstrb[1]) pwm_offset <= pwdata[`DSF_CTRL_OFS_HI:`DSF_CTRL_OFS_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                 irq_mask <= `DSF_RST_MASK;
    else if (wr_mask && pstrb[0]) irq_mask <= pwdata[4:0];
  end

  // Event detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stst_prev  <= 1'b0;
      otpw_prev  <= 1'b0;
      ol_prev    <= 2'b00;
      short_prev <= '0;
    end else begin
      stst_prev  <= stst;
      otpw_prev  <= warn_cmp;
      ol_prev    <= {open_load_phase_b, open_load_phase_a};
      short_prev <= short_shown;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`DSF_IRQ_STST]  = stst & ~stst_prev;
    irq_event[`DSF_IRQ_SHORT] = |(short_shown & ~short_prev);
    irq_event[`DSF_IRQ_OT]    = (next_ot_state == DSF_OT_SHUT) &&
                                (ot_state == DSF_OT_RUN);
    irq_event[`DSF_IRQ_OTPW]  = warn_cmp & ~otpw_prev;
    irq_event[`DSF_IRQ_OL]    =
      |({open_load_phase_b, open_load_phase_a} & ~ol_prev);
  end

  // Sticky status: read clears only bits returned, new events win
  assign irq_read = rd_irq ? prdata[4:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_status <= '0;
    else          irq_status <= (irq_status & ~irq_read) | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= |(((irq_status & ~irq_read) | irq_event) & irq_mask);
  end

  // Voltage-mode PWM for the quiet chopper
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= '0;
      pwm_tick <= 1'b0;
    end else if (div_cnt == ($bits(div_cnt))'(PWM_DIV - 1)) begin
      div_cnt  <= '0;
      pwm_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + ($bits(div_cnt))'(1);
      pwm_tick <= 1'b0;
    end
  end

  assign amp_prod = 14'(pwm_offset) * 14'({1'b0, cs_actual} + 6'h01);
  assign amp      = 9'(amp_prod >> `DSF_CS_SHIFT);
  assign pwm_duty = amp[8] ? 8'hff : amp[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      pwm_cnt <= 8'h00;
    else if (pwm_tick) pwm_cnt <= pwm_cnt + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) coil_pwm <= 1'b0;
    else coil_pwm <= quiet_mode & next_bridge & (pwm_cnt < pwm_duty);
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_status;
  assign rd_status = apb_done & ~pwrite & (paddr == `DSF_ADDR_STATUS);

  property p_stst_restart;
    step_pulse |=> !stst [*2];
  endproperty
  a_stst_restart: assert property (p_stst_restart)
    else $error("standstill flag not cleared by step");

  property p_read_mode_cs;
    rd_status |-> prdata[`DSF_BIT_QUIET] == quiet_mode &&
      prdata[`DSF_CS_HI:`DSF_CS_LO] == $past(cs_actual);
  endproperty
  a_read_mode_cs: assert property (p_read_mode_cs)
    else $error("mode or current scale readback wrong");

  property p_read_temp;
    rd_status |-> prdata[`DSF_TEMP_HI:`DSF_TEMP_LO] == $past(temp_cmp) &&
      prdata[`DSF_BIT_OTPW] == $past(warn_cmp);
  endproperty
  a_read_temp: assert property (p_read_temp)
    else $error("temperature readback wrong");

  property p_ol_no_action;
    ((open_load_phase_a || open_load_phase_b) && !driver_off &&
     short_det == 4'h0 && short_shown == 4'h0 &&
     !shut_cmp && ot_state == DSF_OT_RUN) |=> bridge_enable;
  endproperty
  a_ol_no_action: assert property (p_ol_no_action)
    else $error("bridge disabled without a fault");

  property p_short_disable;
    (short_det != 4'h0 && !driver_off && !wr_ctrl) |=>
      !bridge_enable && (short_shown & $past(short_det)) == $past(short_det);
  endproperty
  a_short_disable: assert property (p_short_disable)
    else $error("short not latched or driver not disabled");

  property p_short_hold;
    (short_shown != 4'h0 && !driver_off) ##1 $stable(quiet_mode) |->
      (short_shown & $past(short_shown)) == $past(short_shown);
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("short flag dropped while driver on");

  property p_short_clear;
    driver_off |=> short_set[0] == 4'h0 && short_set[1] == 4'h0;
  endproperty
  a_short_clear: assert property (p_short_clear)
    else $error("short flags survive switch off");

  property p_ot_shutdown;
    shut_cmp |=> driver_fault_status[`DSF_BIT_OT] && !bridge_enable;
  endproperty
  a_ot_shutdown: assert property (p_ot_shutdown)
    else $error("overtemperature did not shut down");

  property p_ot_cool;
    (ot_state == DSF_OT_SHUT && warn_cmp) |=> ot_state == DSF_OT_SHUT;
  endproperty
  a_ot_cool: assert property (p_ot_cool)
    else $error("left shutdown before prewarning cleared");

  property p_reserved;
    rd_status |-> prdata[`DSF_RSV_HI_HI:`DSF_RSV_HI_LO] == 9'h000 &&
      prdata[`DSF_RSV_LO_HI:`DSF_RSV_LO_LO] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_status_write;
    (apb_done && pwrite && paddr == `DSF_ADDR_STATUS) |=>
      $stable(ctrl_word) && $stable(irq_mask);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write changed a register");

  property p_pwm_off;
    !bridge_enable ##1 !bridge_enable |-> !coil_pwm;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("coil driven while bridges off");

  c_read_status: cover property (rd_status && prdata[`DSF_BIT_STST]);
  c_short_trip: cover property (short_det != 4'h0 ##1 !bridge_enable);
  c_ot_cycle: cover property (ot_state == DSF_OT_SHUT ##[1:20]
                              ot_state == DSF_OT_RUN);
  c_irq: cover property ($rose(irq));
endmodule : dsf_top
`default_nettype wire

// >>> dsf_defines.svh
// Register map, field positions, reset values and timing counts
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

`define DSF_ADDR_CTRL        12'h000
`define DSF_ADDR_IRQ_STATUS  12'h004
`define DSF_ADDR_IRQ_MASK    12'h008
`define DSF_IDX_STATUS       12'h06f
`define DSF_ADDR_STATUS      (`DSF_IDX_STATUS << 2)

`define DSF_BIT_STST         31
`define DSF_BIT_QUIET        30
`define DSF_CS_HI            20
`define DSF_CS_LO            16
`define DSF_TEMP_HI          11
`define DSF_TEMP_LO          8
`define DSF_OL_HI            7
`define DSF_OL_LO            6
`define DSF_SHORT_HI         5
`define DSF_SHORT_LO         2
`define DSF_BIT_OT           1
`define DSF_BIT_OTPW         0
`define DSF_RSV_HI_HI        29
`define DSF_RSV_HI_LO        21
`define DSF_RSV_LO_HI        15
`define DSF_RSV_LO_LO        12

`define DSF_TEMP_157         3
`define DSF_TEMP_150         2
`define DSF_TEMP_143         1
`define DSF_TEMP_120         0

`define DSF_CTRL_CHOPPER_OFF_TIME_HI     3
`define DSF_CTRL_CHOPPER_OFF_TIME_LO     0
`define DSF_CTRL_QUIET       4
`define DSF_CTRL_OTSEL       5
`define DSF_CTRL_OFS_HI      15
`define DSF_CTRL_OFS_LO      8

`define DSF_RST_CHOPPER_OFF_TIME         4'h3
`define DSF_RST_QUIET        1'b1
`define DSF_RST_OTSEL        1'b0
`define DSF_RST_OFS          8'h24
`define DSF_RST_MASK         5'h00

`define DSF_IRQ_STST         0
`define DSF_IRQ_SHORT        1
`define DSF_IRQ_OT           2
`define DSF_IRQ_OTPW         3
`define DSF_IRQ_OL           4

`define DSF_STANDSTILL_CYCLES 1048576
`define DSF_PWM_DIV          4
`define DSF_CS_SHIFT         5

`endif

// >>> dsf_pkg.sv
// Types shared by the driver status flag block
`default_nettype none
package dsf_pkg;
  typedef enum logic [1:0] {
    DSF_OT_RUN  = 2'b01,
    DSF_OT_SHUT = 2'b10
  } dsf_ot_state_type;
  typedef logic [3:0] dsf_short_type;
  typedef logic [4:0] dsf_irq_type;
endpackage : dsf_pkg
`default_nettype wire

// >>> dsf_standstill.sv
// Standstill timer restarted by every step pulse
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
module dsf_standstill #(
  parameter int CYCLES = `DSF_STANDSTILL_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic step_pulse,
  output var  logic stst
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      stst <= 1'b0;
    end else if (step_pulse) begin
      cnt  <= '0;
      stst <= 1'b0;
    end else if (cnt == CW'(CYCLES - 1)) begin
      stst <= 1'b1;
    end else begin
      cnt  <= cnt + CW'(1);
    end
  end
endmodule : dsf_standstill
`default_nettype wire

// >>> dsf_short_latch.sv
// Latched short-circuit flags for one chopper mode
`timescale 1ns/1ps
`default_nettype none
module dsf_short_latch (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  arm,
  input  wire logic                  clr,
  input  wire dsf_pkg::dsf_short_type det,
  output var  dsf_pkg::dsf_short_type flags
);
  import dsf_pkg::*;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (clr) begin
      flags <= '0;
    end else if (arm) begin
      flags <= flags | det;
    end
  end
endmodule : dsf_short_latch
`default_nettype wire

// >>> test_driver_status_flags.sv
// Self-checking testbench for the driver status flag block
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
`define CHK_EQ(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module test_driver_status_flags;
  import dsf_pkg::*;
  localparam int STST_CYC = 16;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, temp_cmp;
  logic        pready, pslverr, err, step_pulse, enable_low_input;
  logic [4:0]  cs_actual;
  logic        open_load_phase_a, open_load_phase_b;
  logic        lowside_short_phase_a, lowside_short_phase_b;
  logic        ground_short_phase_a, ground_short_phase_b;
  logic        bridge_enable, coil_pwm, irq;
  int          num_errors, samples_checked, cnt;

  dsf_top #(.STANDSTILL_CYCLES(STST_CYC), .PWM_DIV(1)) dsf_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse(step_pulse), .enable_low_input(enable_low_input),
    .cs_actual(cs_actual), .temp_cmp(temp_cmp),
    .open_load_phase_a(open_load_phase_a),
    .open_load_phase_b(open_load_phase_b),
    .lowside_short_phase_a(lowside_short_phase_a),
    .lowside_short_phase_b(lowside_short_phase_b),
    .ground_short_phase_a(ground_short_phase_a),
    .ground_short_phase_b(ground_short_phase_b),
    .bridge_enable(bridge_enable), .coil_pwm(coil_pwm), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // One APB transfer; data and error taken at the edge that sees pready
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [31:0] wd, output logic [31:0] d,
                          output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb_xfer

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb_xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask : rd_reg

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, a, wd, d, e);
  endtask : wr_reg

  task automatic wait_neg(input int n);
    repeat (n) @(negedge pclk);
  endtask : wait_neg

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; step_pulse = 1'b0;
    enable_low_input = 1'b0; cs_actual = 5'h15; temp_cmp = 4'h0;
    open_load_phase_a = 1'b0; open_load_phase_b = 1'b0;
    lowside_short_phase_a = 1'b0; lowside_short_phase_b = 1'b0;
    ground_short_phase_a = 1'b0; ground_short_phase_b = 1'b0;
    num_errors = 0; samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_reg(`DSF_ADDR_CTRL, rd);
    `CHK_EQ("ctrl reset", 32'h0000_2413, rd)
    rd_reg(`DSF_ADDR_IRQ_MASK, rd);
    `CHK_EQ("mask reset", 32'h0000_0000, rd)
    end_test("reset");
    // Live fields, reserved bits, ignored write, unmapped address
    @(posedge pclk);
    temp_cmp <= 4'ha; open_load_phase_a <= 1'b1;
    step_pulse <= 1'b1;
    @(posedge pclk);
    step_pulse <= 1'b0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("status word", 32'h4015_0a40, rd)
    apb_xfer(1'b1, `DSF_ADDR_STATUS, 32'hffff_ffff, rd, err);
    `CHK_EQ("status write err", 1'b0, err)
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("status after write", 32'h4015_0a40, rd)
    `CHK_EQ("bridge open load", 1'b1, bridge_enable)
    apb_xfer(1'b0, 12'h100, 32'h0, rd, err);
    `CHK_EQ("unmapped err", 1'b1, err)
    `CHK_EQ("unmapped data", 32'h0000_0000, rd)
    temp_cmp <= 4'h0; open_load_phase_a <= 1'b0;
    end_test("fields");
    // Standstill restarts on a step pulse
    @(posedge pclk);
    step_pulse <= 1'b1;
    @(posedge pclk);
    step_pulse <= 1'b0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("stst moving", 1'b0, rd[31])
    repeat (STST_CYC + 4) @(posedge pclk);
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("stst idle", 1'b1, rd[31])
    end_test("standstill");
    // Short flags, per-mode sets, clearing and interrupt
    wr_reg(`DSF_ADDR_IRQ_MASK, 32'h0000_0002);
    rd_reg(`DSF_ADDR_IRQ_STATUS, rd);
    @(posedge pclk);
    ground_short_phase_a <= 1'b1;
    @(posedge pclk);
    ground_short_phase_a <= 1'b0;
    wait_neg(1);
    `CHK_EQ("bridge short", 1'b0, bridge_enable)
    wait_neg(1);
    `CHK_EQ("irq short", 1'b1, irq)
    @(posedge pclk);
    lowside_short_phase_b <= 1'b1;
    @(posedge pclk);
    lowside_short_phase_b <= 1'b0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("shorts quiet", 32'h4000_0024, rd & 32'h4000_003c)
    rd_reg(`DSF_ADDR_IRQ_STATUS, rd);
    `CHK_EQ("irq status short", 32'h2, rd & 32'h2)
    wait_neg(2);
    `CHK_EQ("irq cleared", 1'b0, irq)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2403);
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("shorts cycle", 32'h0, rd & 32'h4000_003c)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2413);
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("shorts back", 32'h4000_0024, rd & 32'h4000_003c)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2410);
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2413);
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("shorts off time", 32'h0, rd & 32'h3c)
    wait_neg(1);
    `CHK_EQ("bridge restored", 1'b1, bridge_enable)
    @(posedge pclk);
    ground_short_phase_b <= 1'b1;
    @(posedge pclk);
    ground_short_phase_b <= 1'b0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("short b", 32'h08, rd & 32'h3c)
    enable_low_input <= 1'b1;
    repeat (2) @(posedge pclk);
    enable_low_input <= 1'b0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("shorts enable", 32'h0, rd & 32'h3c)
    end_test("shorts");
    // Overtemperature for both limit selections
    temp_cmp <= 4'h1;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("prewarn only", 32'h1, rd & 32'h3)
    temp_cmp <= 4'h5;
    wait_neg(2);
    `CHK_EQ("bridge ot", 1'b0, bridge_enable)
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("ot set", 32'h3, rd & 32'h3)
    temp_cmp <= 4'h1;
    wait_neg(3);
    `CHK_EQ("bridge held", 1'b0, bridge_enable)
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("ot held", 32'h3, rd & 32'h3)
    temp_cmp <= 4'h0;
    wait_neg(3);
    `CHK_EQ("bridge cool", 1'b1, bridge_enable)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2433);
    temp_cmp <= 4'h8;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("ot high limit", 32'h2, rd & 32'h3)
    temp_cmp <= 4'h0;
    rd_reg(`DSF_ADDR_STATUS, rd);
    `CHK_EQ("ot high clear", 32'h0, rd & 32'h3)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2413);
    end_test("overtemp");
    // Voltage PWM only in the quiet chopper
    cnt = 0;
    repeat (300) begin
      @(negedge pclk);
      if (coil_pwm === 1'b1) cnt++;
    end
    `CHK_EQ("pwm quiet", 1'b1, cnt > 0)
    wr_reg(`DSF_ADDR_CTRL, 32'h0000_2403);
    cnt = 0;
    repeat (300) begin
      @(negedge pclk);
      if (coil_pwm !== 1'b0) cnt++;
    end
    `CHK_EQ("pwm cycle", 1'b1, cnt == 0)
    end_test("pwm");
    finish_test();
  end
endmodule : test_driver_status_flags
`undef CHK_EQ
`default_nettype wire
